// file: rtl/sfsf_frame_status_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sfsf_frame_status_fifo #(
    parameter int DEPTH = sfsf_pkg::QUEUE_DEPTH
) (
    // clock and resets
    input  wire logic                     mclk,
    input  wire logic                     reset,
    input  wire logic                     clkEn,
    input  wire logic                     chanReset,
    // control register write
    input  wire logic                     ctrlWrite,
    input  wire logic [7:0]               ctrlData,
    input  wire logic                     sdlcMode,
    // receiver events and live status
    input  wire logic                     rxDataWrite,
    input  wire logic                     rxFlag,
    input  wire logic                     rxEndOfFrame,
    input  wire sfsf_pkg::sfsf_rx_status_t liveStatus,
    // other register sources
    input  wire logic [7:0]               mainStatus,
    input  wire logic [7:0]               vectorValue,
    input  wire logic [7:0]               pendingBits,
    input  wire logic [7:0]               extInfo,
    // host read port
    input  wire sfsf_pkg::sfsf_read_req_t rdReq,
    output logic [7:0]                    rdData,
    // receiver control and state
    output logic                          crcInit,
    output logic                          queueAvail,
    output logic                          queueOverflow
);

    localparam int PW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST_PTR  = PW'(DEPTH - 1);
    localparam logic [LW-1:0] FULL_LVL  = LW'(DEPTH);

    sfsf_pkg::sfsf_entry_t                   queueMem [DEPTH];
    logic [PW-1:0]                           wrPtr;
    logic [PW-1:0]                           rdPtr;
    logic [LW-1:0]                           level;
    logic                                    enableBit;
    logic                                    armed;
    logic [sfsf_pkg::COUNT_WIDTH-1:0]        byteCounter;
    logic                                    queueOn;
    logic                                    flush;
    logic                                    empty;
    logic                                    full;
    logic                                    doPush;
    logic                                    doPop;
    sfsf_pkg::sfsf_entry_t                   head;
    sfsf_pkg::sfsf_entry_t                   newEntry;
    logic [7:0]                              specialLive;
    logic [7:0]                              specialOut;
    logic [7:0]                              next_rdData;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == LAST_PTR) ? '0 : p + PW'(1);
    endfunction : bump

    // queue-enable control bit
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            enableBit <= sfsf_pkg::ENABLE_RESET;
        end else if (clkEn) begin
            if (chanReset) begin
                enableBit <= sfsf_pkg::ENABLE_RESET;
            end else if (ctrlWrite) begin
                enableBit <= ctrlData[sfsf_pkg::ENABLE_BIT];
            end
        end
    end

    // queue state decode
    assign queueOn = enableBit & sdlcMode;
    assign flush   = ~queueOn | chanReset;
    assign empty   = (level == '0);
    assign full    = (level == FULL_LVL);
    assign doPush  = queueOn & rxEndOfFrame & ~full;
    assign doPop   = queueOn & rdReq.strobe & (rdReq.addr == sfsf_pkg::REG_SPECIAL_RX)
                     & armed & ~empty;
    assign head    = queueMem[rdPtr];

    // record captured at end of frame
    assign newEntry.byteCount = byteCounter;
    assign newEntry.residue   = liveStatus.residue;
    assign newEntry.overrun   = liveStatus.overrun;
    assign newEntry.crcError  = liveStatus.crcError;

    // storage array, written only on push
    always_ff @(posedge mclk) begin
        if (clkEn && doPush) begin
            queueMem[wrPtr] <= newEntry;
        end
    end

    // pointers and fill level
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wrPtr <= '0;
            rdPtr <= '0;
            level <= '0;
        end else if (clkEn) begin
            if (flush) begin
                wrPtr <= '0;
                rdPtr <= '0;
                level <= '0;
            end else begin
                if (doPush) begin
                    wrPtr <= bump(wrPtr);
                end
                if (doPop) begin
                    rdPtr <= bump(rdPtr);
                end
                if (doPush && !doPop) begin
                    level <= level + LW'(1);
                end else if (doPop && !doPush) begin
                    level <= level - LW'(1);
                end
            end
        end
    end

    // overflow flag, cleared while the enable bit is low or on channel reset
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            queueOverflow <= 1'b0;
        end else if (clkEn) begin
            if (!enableBit || chanReset) begin
                queueOverflow <= 1'b0;
            end else if (queueOn && rxEndOfFrame && full) begin
                queueOverflow <= 1'b1;
            end
        end
    end

    // pop permission latched by a high count read
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            armed <= 1'b0;
        end else if (clkEn) begin
            if (flush) begin
                armed <= 1'b0;
            end else if (rdReq.strobe && rdReq.addr == sfsf_pkg::REG_COUNT_HIGH) begin
                armed <= ~empty;
            end else if (doPop) begin
                armed <= 1'b0;
            end
        end
    end

    // receive byte counter
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            byteCounter <= sfsf_pkg::COUNT_RESET;
        end else if (clkEn) begin
            if (!sdlcMode) begin
                byteCounter <= sfsf_pkg::COUNT_RESET;
            end else if (rxFlag) begin
                byteCounter <= sfsf_pkg::COUNT_RESET;
            end else if (rxDataWrite) begin
                byteCounter <= byteCounter + 14'h0001;
            end
        end
    end

    // crc checker restart after each frame
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            crcInit <= 1'b0;
        end else if (clkEn) begin
            crcInit <= rxEndOfFrame;
        end
    end

    assign queueAvail = queueOn & ~empty;

    // special status composed from live and queued bits
    always_comb begin
        specialLive = {liveStatus.endOfFrame, liveStatus.crcError, liveStatus.overrun,
                       liveStatus.parity, liveStatus.residue, liveStatus.allSent};
        specialOut  = specialLive;
        if (queueAvail) begin
            specialOut = {liveStatus.endOfFrame, head.crcError, head.overrun,
                          liveStatus.parity, head.residue, liveStatus.allSent};
        end
    end

    // read multiplexer
    always_comb begin
        next_rdData = sfsf_pkg::READ_RESET;
        unique case (rdReq.addr)
            sfsf_pkg::REG_MAIN_STATUS, sfsf_pkg::REG_MAIN_MIRROR: next_rdData = mainStatus;
            sfsf_pkg::REG_SPECIAL_RX: next_rdData = specialOut;
            sfsf_pkg::REG_VECTOR:     next_rdData = vectorValue;
            sfsf_pkg::REG_PENDING:    next_rdData = pendingBits;
            sfsf_pkg::REG_RX_MIRROR:  next_rdData = specialLive;
            sfsf_pkg::REG_COUNT_LOW: begin
                if (!queueOn) next_rdData = vectorValue;
                else if (!empty) next_rdData = head.byteCount[7:0];
                else next_rdData = byteCounter[7:0];
            end
            sfsf_pkg::REG_COUNT_HIGH: begin
                if (!queueOn) next_rdData = pendingBits;
                else if (!empty) next_rdData = {queueOverflow, 1'b1, head.byteCount[13:8]};
                else next_rdData = {queueOverflow, 1'b0, byteCounter[13:8]};
            end
            sfsf_pkg::REG_EXT_INFO: begin
                next_rdData = extInfo;
                next_rdData[sfsf_pkg::ENABLE_BIT] = enableBit;
            end
            default: next_rdData = sfsf_pkg::READ_RESET;
        endcase
    end

    // read data register, loaded by each read strobe while clkEn is high
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdData <= sfsf_pkg::READ_RESET;
        end else if (clkEn && rdReq.strobe) begin
            rdData <= next_rdData;
        end
    end

    // checks on the queue
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_level_bound: assert property (level <= FULL_LVL)
        else $error("status queue level above depth");
    a_push_grows: assert property (clkEn && doPush && !doPop && !flush |=> level == $past(level) + LW'(1))
        else $error("push did not grow level");
    a_pop_shrinks: assert property (clkEn && doPop && !doPush && !flush |=> level == $past(level) - LW'(1))
        else $error("pop did not shrink level");
    a_no_empty_pop: assert property (empty |-> !doPop)
        else $error("pop from empty queue");
    a_flush_clears: assert property (clkEn && flush |=> level == '0 && wrPtr == '0 && rdPtr == '0)
        else $error("pointers not cleared");
    a_full_sets_ovf: assert property (clkEn && queueOn && rxEndOfFrame && full && !chanReset && !doPop
                                      |=> queueOverflow && level == FULL_LVL)
        else $error("overflow missed or entry kept");
    a_ovf_sticky: assert property (queueOverflow && enableBit && !chanReset |=> queueOverflow)
        else $error("overflow cleared while enabled");
    a_drop_keeps_ptr: assert property (clkEn && queueOn && rxEndOfFrame && full && !chanReset
                                       |=> wrPtr == $past(wrPtr))
        else $error("dropped frame moved write pointer");
    a_armed_latch: assert property (clkEn && !flush && rdReq.strobe && rdReq.addr == sfsf_pkg::REG_COUNT_HIGH
                                    |=> armed == $past(!empty))
        else $error("high count read did not latch availability");
    a_pop_moves_ptr: assert property (clkEn && doPop && !flush
                                      |=> rdPtr == bump($past(rdPtr)))
        else $error("pop did not advance read pointer");
    a_flag_clears: assert property (clkEn && sdlcMode && rxFlag |=> byteCounter == '0)
        else $error("counter not cleared by flag");
    a_count_inc: assert property (clkEn && sdlcMode && !rxFlag && rxDataWrite
                                  |=> byteCounter == $past(byteCounter) + 14'h0001)
        else $error("counter not incremented");
    a_count_idle: assert property (clkEn && !sdlcMode |=> byteCounter == '0)
        else $error("counter ran outside sdlc mode");
    a_crc_restart: assert property (clkEn && rxEndOfFrame |=> crcInit)
        else $error("crc restart missing");
    a_mirror_read: assert property (clkEn && rdReq.strobe && rdReq.addr == sfsf_pkg::REG_MAIN_MIRROR
                                    |=> rdData == $past(mainStatus))
        else $error("mirror read wrong");
    a_enable_info: assert property (clkEn && rdReq.strobe && rdReq.addr == sfsf_pkg::REG_EXT_INFO
                                    |=> rdData[sfsf_pkg::ENABLE_BIT] == $past(enableBit))
        else $error("enable state not reported");
    a_avail_bit: assert property (clkEn && queueOn && rdReq.strobe && rdReq.addr == sfsf_pkg::REG_COUNT_HIGH
                                  |=> rdData[sfsf_pkg::AVAIL_BIT] == $past(!empty))
        else $error("availability bit wrong");

    c_frame_queued: cover property (clkEn && doPush ##[1:20] doPop);
    c_queue_full:   cover property (full && queueOn);
    c_overflow:     cover property ($rose(queueOverflow));
    c_bypass_read:  cover property (clkEn && queueOn && empty && rdReq.strobe
                                    && rdReq.addr == sfsf_pkg::REG_SPECIAL_RX);

endmodule : sfsf_frame_status_fifo
`default_nettype wire

// file: rtl/sfsf_pkg.sv
package sfsf_pkg;

    // queue geometry
    localparam int QUEUE_DEPTH = 10;
    localparam int ENTRY_WIDTH = 19;
    localparam int COUNT_WIDTH = 14;

    // read register indices
    localparam logic [3:0] REG_MAIN_STATUS   = 4'h0;
    localparam logic [3:0] REG_SPECIAL_RX    = 4'h1;
    localparam logic [3:0] REG_VECTOR        = 4'h2;
    localparam logic [3:0] REG_PENDING       = 4'h3;
    localparam logic [3:0] REG_MAIN_MIRROR   = 4'h4;
    localparam logic [3:0] REG_RX_MIRROR     = 4'h5;
    localparam logic [3:0] REG_COUNT_LOW     = 4'h6;
    localparam logic [3:0] REG_COUNT_HIGH    = 4'h7;
    localparam logic [3:0] REG_EXT_INFO      = 4'hf;

    // field positions
    localparam int ENABLE_BIT    = 2;   // control and info registers
    localparam int AVAIL_BIT     = 6;   // high count register
    localparam int OVERFLOW_BIT  = 7;   // high count register

    // reset values
    localparam logic                   ENABLE_RESET = 1'b0;
    localparam logic [COUNT_WIDTH-1:0] COUNT_RESET  = 14'h0000;
    localparam logic [7:0]             READ_RESET   = 8'h00;

    // live receive status bits
    typedef struct packed {
        logic       endOfFrame;
        logic       crcError;
        logic       overrun;
        logic       parity;
        logic [2:0] residue;
        logic       allSent;
    } sfsf_rx_status_t;

    // one queued frame record, 19 bits
    typedef struct packed {
        logic [COUNT_WIDTH-1:0] byteCount;
        logic [2:0]             residue;
        logic                   overrun;
        logic                   crcError;
    } sfsf_entry_t;

    // read request from the host side
    typedef struct packed {
        logic       strobe;
        logic [3:0] addr;
    } sfsf_read_req_t;

endpackage : sfsf_pkg

// file: tb/sfsf_rx_source.sv
`timescale 1ns/1ps
`default_nettype none
module sfsf_rx_source (
    // clock
    input  wire logic mclk,
    // receiver events towards the block
    output logic      rxDataWrite,
    output logic      rxFlag,
    output logic      rxEndOfFrame
);
    // idle receiver at time zero
    initial begin
        rxDataWrite = 1'b0;
        rxFlag = 1'b0;
        rxEndOfFrame = 1'b0;
    end

    // one byte per cycle, then an optional closing flag; entered at a falling edge
    task automatic send_frame(input int n, input bit close);
        for (int i = 0; i < n; i++) begin
            rxDataWrite = 1'b1;
            @(negedge mclk);
        end
        rxDataWrite = 1'b0;
        if (close) begin
            rxFlag = 1'b1;
            rxEndOfFrame = 1'b1;
            @(negedge mclk);
            rxFlag = 1'b0;
            rxEndOfFrame = 1'b0;
        end
    endtask : send_frame
endmodule : sfsf_rx_source
`default_nettype wire

// file: tb/sfsf_frame_status_fifo_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sfsf_frame_status_fifo_bench;
    logic mclk, reset, chanReset, ctrlWrite, sdlcMode, crcInit, queueAvail, queueOverflow;
    logic clkEn;
    logic rxDataWrite, rxFlag, rxEndOfFrame;
    logic [7:0] ctrlData, mainStatus, vectorValue, pendingBits, extInfo, rdData, got;
    logic [31:0] r;
    logic [31:0] seed = 32'h42;
    sfsf_pkg::sfsf_rx_status_t liveStatus;
    sfsf_pkg::sfsf_read_req_t  rdReq;
    int failCount = 0, checked = 0, cycles = 0, cnt = 0;
    int q[$];
    bit en = 0, ovf = 0, armed = 0;

    sfsf_frame_status_fifo #(.DEPTH(10)) sfsf_frame_status_fifo_inst (
        .mclk(mclk), .reset(reset), .clkEn(clkEn), .chanReset(chanReset), .ctrlWrite(ctrlWrite),
        .ctrlData(ctrlData), .sdlcMode(sdlcMode), .rxDataWrite(rxDataWrite), .rxFlag(rxFlag),
        .rxEndOfFrame(rxEndOfFrame), .liveStatus(liveStatus), .mainStatus(mainStatus),
        .vectorValue(vectorValue), .pendingBits(pendingBits), .extInfo(extInfo), .rdReq(rdReq),
        .rdData(rdData), .crcInit(crcInit), .queueAvail(queueAvail), .queueOverflow(queueOverflow));
    sfsf_rx_source sfsf_rx_source_inst (.mclk(mclk), .rxDataWrite(rxDataWrite), .rxFlag(rxFlag),
        .rxEndOfFrame(rxEndOfFrame));

    // clock and hang guard
    always #25 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            failCount++;
            finalReport();
        end
    end

    // xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checked++;
        if (seen !== exp) begin
            failCount++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : cmp8

    task automatic cmp1(input string what, input logic exp, input logic seen);
        checked++;
        if (seen !== exp) begin
            failCount++;
            $display("unexpected %s: expected %b, seen %b", what, exp, seen);
        end
    endtask : cmp1

    task automatic chkFlags();
        cmp1("queueAvail", en && sdlcMode && q.size() > 0, queueAvail);
        cmp1("queueOverflow", ovf, queueOverflow);
    endtask : chkFlags

    // reference register contents from the model
    function automatic logic [7:0] expReg(input logic [3:0] a);
        logic [13:0] c;
        logic [7:0]  s;
        bit          on;
        int          h;
        on = en && sdlcMode;
        h = (q.size() > 0) ? q[0] : 0;
        c = (on && q.size() > 0) ? 14'(h >> 5) : 14'(cnt);
        s = liveStatus;
        if (on && q.size() > 0) begin
            s[6] = h[0];
            s[5] = h[1];
            s[3:1] = h[4:2];
        end
        case (a)
            4'h0, 4'h4: expReg = mainStatus;
            4'h1: expReg = s;
            4'h2: expReg = vectorValue;
            4'h3: expReg = pendingBits;
            4'h5: expReg = liveStatus;
            4'h6: expReg = on ? c[7:0] : vectorValue;
            4'h7: expReg = on ? {ovf, q.size() > 0, c[13:8]} : pendingBits;
            4'hf: expReg = {extInfo[7:3], en, extInfo[1:0]};
            default: expReg = 8'h00;
        endcase
    endfunction : expReg

    // one host read, then model pop bookkeeping
    task automatic chkRd(input logic [3:0] a);
        logic [7:0] e;
        e = expReg(a);
        rdReq = {1'b1, a};
        @(negedge mclk);
        got = rdData;
        rdReq = '0;
        @(negedge mclk);
        cmp8($sformatf("register %h", a), e, got);
        if (a == 4'h7) armed = en && sdlcMode && q.size() > 0;
        if (a == 4'h1 && armed && q.size() > 0) begin
            void'(q.pop_front());
            armed = 0;
        end
        chkFlags();
    endtask : chkRd

    // full frame with random status, closed by flag
    task automatic frame(input int nb);
        r = rnd();
        liveStatus = r[7:0];
        sfsf_rx_source_inst.send_frame(nb, 1'b1);
        if (sdlcMode) cnt += nb;
        if (en && sdlcMode && q.size() == 10) ovf = 1;
        else if (en && sdlcMode) q.push_back((cnt << 5) | (int'(r[3:1]) << 2) | (int'(r[5]) << 1) | int'(r[6]));
        cnt = 0;
        cmp1("crcInit", 1'b1, crcInit);
        chkFlags();
    endtask : frame

    task automatic setEn(input bit v);
        r = rnd();
        ctrlData = {r[4:0], v, r[6:5]};
        ctrlWrite = 1'b1;
        @(negedge mclk);
        ctrlWrite = 1'b0;
        en = v;
        if (!v) begin
            q.delete();
            ovf = 0;
            armed = 0;
        end
        // overflow clears one edge after the enable bit falls
        @(negedge mclk);
        chkFlags();
    endtask : setEn

    task automatic finalReport();
        $display("comparisons %0d, mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finalReport

    // main sequence
    initial begin
        mclk = 0; reset = 1; chanReset = 0; ctrlWrite = 0; ctrlData = 0; sdlcMode = 1; liveStatus = '0; rdReq = '0;
        clkEn = 1;
        r = rnd();
        {mainStatus, vectorValue, pendingBits, extInfo} = r;
        repeat (10) @(negedge mclk);
        reset = 0;
        @(negedge mclk);
        for (int a = 0; a < 16; a++) chkRd(4'(a));
        $display("test reset and mirrors done");
        setEn(1);
        chkRd(4'hf);
        for (int i = 0; i < 11; i++) frame(int'(rnd() % 300) + 1);
        for (int i = 0; i < 10; i++) begin
            chkRd(4'h7);
            chkRd(4'h6);
            chkRd(4'h1);
        end
        chkRd(4'h7);
        chkRd(4'h1);
        chkRd(4'h1);
        $display("test fill and drain done");
        frame(5);
        chkRd(4'h1);
        chkRd(4'h1);
        setEn(0);
        chkRd(4'h6);
        setEn(1);
        chkRd(4'h7);
        $display("test toggle done");
        sfsf_rx_source_inst.send_frame(7, 1'b0);
        cnt += 7;
        chkRd(4'h6);
        sdlcMode = 0;
        // leaving sdlc mode flushes the queue and the pop permission
        q.delete();
        armed = 0;
        sfsf_rx_source_inst.send_frame(4, 1'b0);
        cnt = 0;
        frame(3);
        chkRd(4'h7);
        sdlcMode = 1;
        chkRd(4'h6);
        $display("test counter and mode done");
        // frozen clock enable: end of frame and bytes must leave no trace
        clkEn = 0;
        sfsf_rx_source_inst.send_frame(0, 1'b1);
        sfsf_rx_source_inst.send_frame(3, 1'b0);
        clkEn = 1;
        cmp1("crcInit", 1'b0, crcInit);
        chkRd(4'h6);
        $display("test clock enable done");
        frame(4);
        chanReset = 1;
        @(negedge mclk);
        chanReset = 0;
        en = 0;
        q.delete();
        ovf = 0;
        armed = 0;
        chkRd(4'hf);
        $display("test channel reset done");
        finalReport();
    end
endmodule : sfsf_frame_status_fifo_bench
`default_nettype wire
